/* hw/irp_bank.sv */
// AXI4-Lite register bank for input thirteen/fourteen priorities and input one monitor setup.
`timescale 1ns/1ns
module irp_bank #(
    parameter int ADDR_W = 12
) (
    // Clock, reset and enable.
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // AXI4-Lite write address channel.
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response channel.
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address channel.
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data channel.
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Priorities for the main timing path selection engine.
    output logic      [3:0]        main_prio_thirteen,
    output logic      [3:0]        main_prio_fourteen,
    // Priorities for the secondary timing path selection engine.
    output logic      [3:0]        sec_prio_thirteen,
    output logic      [3:0]        sec_prio_fourteen,
    // Input one activity monitor setup and the current path copy selection.
    output logic      [1:0]        input_one_monitor_profile,
    output logic                   path_copy_select
);

    typedef struct packed {
        logic              aw_rdy;
        logic              w_rdy;
        logic              ar_rdy;
        logic              aw_have;
        logic              w_have;
        logic [ADDR_W-1:0] waddr;
        logic [7:0]        wbyte;
        logic              wlane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [7:0]        rbyte;
        logic              sel_sec;
        logic [1:0]        profile;
    } irp_bank_s;

    irp_bank_s s_reg;
    irp_bank_s s_next;

    // Write enables and read views of the two path copies.
    logic       we_main;
    logic       we_sec;
    logic [3:0] main13;
    logic [3:0] main14;
    logic [3:0] sec13;
    logic [3:0] sec14;
    logic [9:0] widx;
    logic [9:0] ridx;
    logic       wfire;
    logic [7:0] prio_view;

    assign widx  = s_reg.waddr[11:2];
    assign ridx  = s_axi_araddr[11:2];
    assign wfire = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;

    // The path-select bit steers writes of the priority register to one copy only.
    assign we_main = wfire && s_reg.wlane0 && (widx == irp_pkg::IDX_PRIO)
                     && !s_reg.sel_sec; // [R4]
    assign we_sec  = wfire && s_reg.wlane0 && (widx == irp_pkg::IDX_PRIO)
                     && s_reg.sel_sec; // [R4]

    // Reads of the priority register show the copy that the path-select bit names.
    assign prio_view = s_reg.sel_sec ? {sec14, sec13} : {main14, main13}; // [R4]

    // Main timing path copy, reset to FE.
    irp_prio_copy #(
        .RESET_VAL (irp_pkg::PRIO_MAIN_RST)
    ) u_main (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ce            (ce),
        .we            (we_main),
        .wdata         (s_reg.wbyte),
        .prio_thirteen (main13),
        .prio_fourteen (main14)
    );

    // Secondary timing path copy, reset to zero.
    irp_prio_copy #(
        .RESET_VAL (irp_pkg::PRIO_SEC_RST)
    ) u_sec (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ce            (ce),
        .we            (we_sec),
        .wdata         (s_reg.wbyte),
        .prio_thirteen (sec13),
        .prio_fourteen (sec14)
    );

    // Bus slave: address and data are caught in either order, then written together.
    always_comb begin
        s_next = s_reg;
        // Write address capture.
        if (s_reg.aw_rdy && s_axi_awvalid) begin
            s_next.aw_have = 1'b1;
            s_next.aw_rdy  = 1'b0;
            s_next.waddr   = s_axi_awaddr;
        end
        // Write data capture; only the low byte lane carries register bits.
        if (s_reg.w_rdy && s_axi_wvalid) begin
            s_next.w_have = 1'b1;
            s_next.w_rdy  = 1'b0;
            s_next.wbyte  = s_axi_wdata[7:0];
            s_next.wlane0 = s_axi_wstrb[0];
        end
        // Register update once both halves are held.
        if (wfire) begin
            s_next.aw_have = 1'b0;
            s_next.w_have  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = irp_pkg::RESP_OKAY;
            case (widx)
                irp_pkg::IDX_PRIO: begin
                    s_next.bresp = irp_pkg::RESP_OKAY;
                end
                irp_pkg::IDX_MON_CFG: begin
                    // Only the profile field is stored; the other bits are kept at zero.
                    if (s_reg.wlane0) begin
                        s_next.profile = s_reg.wbyte[irp_pkg::PROFILE_LSB +: 2]; // [R5] [R6]
                    end
                end
                irp_pkg::IDX_PATH_SEL: begin
                    if (s_reg.wlane0) begin
                        s_next.sel_sec = s_reg.wbyte[irp_pkg::PATH_SEL_BIT]; // [R4]
                    end
                end
                default: begin
                    s_next.bresp = irp_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Write response handshake reopens both write channels.
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
            s_next.aw_rdy = 1'b1;
            s_next.w_rdy  = 1'b1;
        end
        // Read address taken; data is answered on the next cycle.
        if (s_reg.ar_rdy && s_axi_arvalid) begin
            s_next.ar_rdy = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp  = irp_pkg::RESP_OKAY;
            case (ridx)
                irp_pkg::IDX_PRIO: begin
                    s_next.rbyte = prio_view; // [R1] [R2]
                end
                irp_pkg::IDX_MON_CFG: begin
                    s_next.rbyte = {2'h0, s_reg.profile, 4'h0}; // [R6]
                end
                irp_pkg::IDX_PATH_SEL: begin
                    s_next.rbyte = {3'h0, s_reg.sel_sec, 4'h0};
                end
                default: begin
                    s_next.rbyte = 8'h00;
                    s_next.rresp = irp_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Read data handshake reopens the read address channel.
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
            s_next.ar_rdy = 1'b1;
        end
    end

    // State register; reset acts on any rising clock edge whatever the enable, the clock enable freezes everything else while low.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg         <= '0;
            s_reg.aw_rdy  <= 1'b1;
            s_reg.w_rdy   <= 1'b1;
            s_reg.ar_rdy  <= 1'b1;
            s_reg.sel_sec <= irp_pkg::PATH_SEL_RST;
            s_reg.profile <= irp_pkg::PROFILE_RST; // [R6]
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Bus outputs straight from the state register.
    assign s_axi_awready = s_reg.aw_rdy;
    assign s_axi_wready  = s_reg.w_rdy;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_arready = s_reg.ar_rdy;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rresp   = s_reg.rresp;
    assign s_axi_rdata   = {24'h000000, s_reg.rbyte};

    // Configuration outputs from the copies and the local fields.
    assign main_prio_thirteen        = main13;
    assign main_prio_fourteen        = main14;
    assign sec_prio_thirteen         = sec13;
    assign sec_prio_fourteen         = sec14;
    assign input_one_monitor_profile = s_reg.profile;
    assign path_copy_select          = s_reg.sel_sec;

endmodule

/* hw/irp_pkg.sv */
// Package with the register map, field layout and reset values of the priority bank.
// Operation
// [R1] Bits 7:4 of the priority register rank reference input fourteen; zero removes it.
// [R2] Bits 3:0 of the priority register rank reference input thirteen; zero removes it.
// [R3] Main and secondary paths keep separate priority copies, resetting to FE and 00.
// [R4] Bit 4 of the path-select register picks which copy the priority register reaches.
// [R5] Bits 5:4 of the input one register pick one of four leaky-bucket profiles.
// [R6] Other input one bits are written as zero, the input is 8 kHz only, reset is zero.
package irp_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [9:0] IDX_PRIO     = 10'h01E;
    localparam logic [9:0] IDX_MON_CFG  = 10'h020;
    localparam logic [9:0] IDX_PATH_SEL = 10'h04B;

    // Field positions.
    localparam int PRIO14_LSB   = 4;
    localparam int PRIO13_LSB   = 0;
    localparam int PROFILE_LSB  = 4;
    localparam int PATH_SEL_BIT = 4;

    // Reset values.
    localparam logic [7:0] PRIO_MAIN_RST = 8'hFE;
    localparam logic [7:0] PRIO_SEC_RST  = 8'h00;
    localparam logic [1:0] PROFILE_RST   = 2'h0;
    localparam logic       PATH_SEL_RST  = 1'b0;

    // Input one runs at this frame rate only.
    localparam int MON_FREQ_KHZ = 8;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* hw/irp_prio_copy.sv */
// One path copy of the input thirteen and fourteen priority register.
`timescale 1ns/1ns
module irp_prio_copy #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // Clock, reset and enable.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    // Write port from the bus slave.
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    // Stored priorities.
    output logic      [3:0] prio_thirteen,
    output logic      [3:0] prio_fourteen
);

    typedef struct packed {
        logic [3:0] fourteen;
        logic [3:0] thirteen;
    } irp_copy_s;

    irp_copy_s s_reg;
    irp_copy_s s_next;

    // A write replaces both nibbles; zero in a nibble drops that input from selection.
    always_comb begin
        s_next = s_reg;
        if (we) begin
            s_next.fourteen = wdata[irp_pkg::PRIO14_LSB +: 4]; // [R1]
            s_next.thirteen = wdata[irp_pkg::PRIO13_LSB +: 4]; // [R2]
        end
    end

    // State register with its own reset value per path.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= RESET_VAL; // [R3]
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign prio_thirteen = s_reg.thirteen;
    assign prio_fourteen = s_reg.fourteen;

endmodule

/* tb/irp_bank_asserts.sv */
// Checker that watches the priority bank ports.
`timescale 1ns/1ns
module irp_bank_asserts (
    // Clock, reset and enable.
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    // Bus handshakes and answers.
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic [1:0]  s_axi_bresp,
    // Stored settings.
    input wire logic [3:0]  main_prio_thirteen,
    input wire logic [3:0]  main_prio_fourteen,
    input wire logic [3:0]  sec_prio_thirteen,
    input wire logic [3:0]  sec_prio_fourteen,
    input wire logic [1:0]  input_one_monitor_profile,
    input wire logic        path_copy_select
);
    // All properties sample the rising edge; all but AST_RST sleep while reset is low.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST: assert property (disable iff (1'b0) !aresetn |=>
        {main_prio_fourteen, main_prio_thirteen, sec_prio_fourteen, sec_prio_thirteen} == 16'hFE00
        && input_one_monitor_profile == 2'h0 && !path_copy_select) else $error("bad reset value");
    AST_MAIN: assert property ($changed({main_prio_fourteen, main_prio_thirteen}) |->
        !path_copy_select && $rose(s_axi_bvalid)) else $error("main copy changed wrongly");
    AST_SEC: assert property ($changed({sec_prio_fourteen, sec_prio_thirteen}) |->
        path_copy_select && $rose(s_axi_bvalid)) else $error("secondary copy changed wrongly");
    AST_PATH: assert property ($changed(path_copy_select) |->
        $rose(s_axi_bvalid) && s_axi_bresp == 2'h0) else $error("path select changed wrongly");
    AST_PROF: assert property ($changed(input_one_monitor_profile) |->
        $rose(s_axi_bvalid) && s_axi_bresp == 2'h0) else $error("profile changed wrongly");
    AST_RDZ: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_RANS: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
        else $error("read answer late");
    // Main scenarios reached.
    CV_WR: cover property ($rose(s_axi_bvalid));
    CV_SEC: cover property ($changed(sec_prio_thirteen));
    CV_PROF: cover property (input_one_monitor_profile == 2'h3);
endmodule
bind irp_bank irp_bank_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
    .main_prio_thirteen(main_prio_thirteen), .main_prio_fourteen(main_prio_fourteen),
    .sec_prio_thirteen(sec_prio_thirteen), .sec_prio_fourteen(sec_prio_fourteen),
    .input_one_monitor_profile(input_one_monitor_profile), .path_copy_select(path_copy_select));

/* tb/test_input_ref_priority_and_monitor_cfg.sv */
// Self-checking bench for the priority and monitor register bank.
`timescale 1ns/1ns
module test_input_ref_priority_and_monitor_cfg;
    localparam logic [11:0] A_PRI = {irp_pkg::IDX_PRIO, 2'b00};
    localparam logic [11:0] A_CFG = {irp_pkg::IDX_MON_CFG, 2'b00};
    localparam logic [11:0] A_SEL = {irp_pkg::IDX_PATH_SEL, 2'b00};
    localparam logic [1:0]  OK    = irp_pkg::RESP_OKAY;
    logic        aclk = 0, aresetn = 0, ce = 1;
    logic [11:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rd;
    logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr, bv, arr, rv, psel;
    logic [1:0]  br, rr, prof;
    logic [3:0]  m13, m14, s13, s14;
    logic [3:0]  ws = 4'hF;
    int          error_cnt = 0, checks = 0;
    // Clock at 50 MHz.
    always #10 aclk = ~aclk;
    irp_bank dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .main_prio_thirteen(m13), .main_prio_fourteen(m14), .sec_prio_thirteen(s13),
        .sec_prio_fourteen(s14), .input_one_monitor_profile(prof), .path_copy_select(psel));
    // Prints the verdict and ends the run.
    task automatic summarize();
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Compares one value and counts a mismatch.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Compares all stored settings at once.
    task automatic chk_out(input logic [15:0] p, input logic [1:0] f, input logic s);
        chk({13'h0, m14, m13, s14, s13, prof, psel}, {13'h0, p, f, s});
    endtask
    // Waits one edge and ends the run when a wait overruns.
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 50) begin
            error_cnt++;
            summarize();
        end
    endtask
    // Bus write, address and data offered together.
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
        int n = 0;
        aw <= a;
        wd <= {24'h0, d};
        awv <= 1;
        wv <= 1;
        bry <= 1;
        do begin
            tick(n);
            if (awr && awv) awv <= 0;
            if (wr && wv) wv <= 0;
        end while (!(bv && bry));
        bry <= 0;
        chk({30'h0, br}, {30'h0, e});
        @(posedge aclk);
    endtask
    // Bus read with expected data and response.
    task automatic rd_reg(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
        int n = 0;
        ar <= a;
        arv <= 1;
        rry <= 1;
        do begin
            tick(n);
            if (arr && arv) arv <= 0;
        end while (!(rv && rry));
        rry <= 0;
        chk(rd, {24'h0, d});
        chk({30'h0, rr}, {30'h0, e});
        @(posedge aclk);
    endtask
    // Holds reset low for six cycles.
    task automatic rst();
        aresetn <= 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
    endtask
    // Reset values at the ports and over the bus.
    task automatic t_reset();
        chk_out(16'hFE00, 2'h0, 1'b0);
        rd_reg(A_PRI, 8'hFE, OK);
        rd_reg(A_CFG, 8'h00, OK);
        rd_reg(A_SEL, 8'h00, OK);
    endtask
    // Rank zero and rank fifteen in the main copy.
    task automatic t_main();
        wr_reg(A_PRI, 8'h0F, OK);
        chk_out(16'h0F00, 2'h0, 1'b0);
        rd_reg(A_PRI, 8'h0F, OK);
    endtask
    // Secondary copy reached through the path select bit.
    task automatic t_sec();
        wr_reg(A_SEL, 8'h10, OK);
        wr_reg(A_PRI, 8'hA1, OK);
        chk_out(16'h0FA1, 2'h0, 1'b1);
        rd_reg(A_PRI, 8'hA1, OK);
        wr_reg(A_SEL, 8'h00, OK);
        rd_reg(A_PRI, 8'h0F, OK);
    endtask
    // Every monitor profile code, always with the other bits written as zero.
    task automatic t_mon();
        for (int c = 0; c < 4; c++) begin
            wr_reg(A_CFG, {2'h0, c[1:0], 4'h0}, OK);
            chk_out(16'h0FA1, c[1:0], 1'b0);
            rd_reg(A_CFG, {2'h0, c[1:0], 4'h0}, OK);
        end
        wr_reg(A_CFG, 8'h10, OK);
        rd_reg(A_CFG, 8'h10, OK);
        wr_reg(A_CFG, 8'h30, OK);
        chk_out(16'h0FA1, 2'h3, 1'b0);
    endtask
    // Unmapped place refused, and a write without the low byte lane ignored.
    task automatic t_err();
        wr_reg(12'h004, 8'h55, irp_pkg::RESP_SLVERR);
        ws <= 4'hE;
        wr_reg(A_PRI, 8'h77, OK);
        ws <= 4'hF;
        chk_out(16'h0FA1, 2'h3, 1'b0);
        rd_reg(12'h004, 8'h00, irp_pkg::RESP_SLVERR);
    endtask
    // A low clock enable holds a taken write back until it rises again.
    task automatic t_ce();
        int n = 0;
        aw <= A_PRI;
        wd <= 32'h00000033;
        awv <= 1;
        wv <= 1;
        tick(n);
        chk({29'h0, awr, wr, arr}, 32'h00000007);
        awv <= 0;
        wv <= 0;
        ce <= 0;
        repeat (4) tick(n);
        chk_out(16'h0FA1, 2'h3, 1'b0);
        chk({31'h0, bv}, 32'h00000000);
        ce <= 1;
        bry <= 1;
        do tick(n); while (!bv);
        bry <= 0;
        chk({30'h0, br}, {30'h0, OK});
        chk_out(16'h33A1, 2'h3, 1'b0);
        @(posedge aclk);
    endtask
    // Main sequence with a second reset in mid-run.
    initial begin
        rst();
        t_reset();
        t_main();
        t_sec();
        t_mon();
        t_err();
        t_ce();
        rst();
        t_reset();
        summarize();
    end
endmodule
